// File: rtl/dsp_acc_pkg.sv
// Constants and enumerations for the accumulator datapath
package dsp_acc_pkg;

  localparam logic [3:0] IDX_CORE_CONFIG = 4'h0;
  localparam logic [3:0] IDX_TRAP_CONTROL = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_WB_POINTER = 4'h3;
  localparam logic [3:0] IDX_ACC_FIRST_LO = 4'h4;
  localparam logic [3:0] IDX_ACC_FIRST_HI = 4'h5;
  localparam logic [3:0] IDX_ACC_SECOND_LO = 4'h6;
  localparam logic [3:0] IDX_ACC_SECOND_HI = 4'h7;

  localparam int CFG_FIRST_CLIP_EN = 7;
  localparam int CFG_SECOND_CLIP_EN = 6;
  localparam int CFG_STORE_CLIP_EN = 5;
  localparam int CFG_CLIP_WIDTH = 4;
  localparam int CFG_ROUND_STYLE = 1;

  localparam int TRAP_FIRST_GUARD = 0;
  localparam int TRAP_SECOND_GUARD = 1;
  localparam int TRAP_WRAP = 2;

  localparam int ST_FIRST_GUARD = 0;
  localparam int ST_SECOND_GUARD = 1;
  localparam int ST_FIRST_CLIP = 2;
  localparam int ST_SECOND_CLIP = 3;
  localparam int ST_EITHER_GUARD = 4;
  localparam int ST_EITHER_CLIP = 5;

  localparam logic [39:0] SAT40_POS = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
  localparam logic [39:0] SAT32_POS = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT32_NEG = 40'hFF_8000_0000;
  localparam logic [23:0] STORE_POS_LIMIT = 24'h00_7FFF;
  localparam logic [23:0] STORE_NEG_LIMIT = 24'hFF_8000;
  localparam logic [15:0] STORE_POS_WORD = 16'h7FFF;
  localparam logic [15:0] STORE_NEG_WORD = 16'h8000;
  localparam logic [15:0] ROUND_HALF = 16'h8000;
  localparam logic [15:0] WB_STEP = 16'h0002;
  localparam logic [5:0] SHIFT_MAX = 6'h10;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] TRAP_EN_RESET = 3'h0;
  localparam logic [15:0] WB_PTR_RESET = 16'h0000;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ACCUM = 2'b01,
    OP_STORE = 2'b10,
    OP_SHIFT = 2'b11
  } op_kind_t;

  typedef enum logic [1:0] {
    WB_NONE = 2'b00,
    WB_REG_DIRECT = 2'b01,
    WB_POST_INC = 2'b10
  } wb_mode_t;

  typedef enum logic [1:0] {
    SRC_FIRST = 2'b00,
    SRC_SECOND = 2'b01,
    SRC_XBUS = 2'b10
  } shift_src_t;

endpackage : dsp_acc_pkg

// File: rtl/dsp_accumulator_datapath.sv
// Accumulator adder, saturation, rounding, store clipping and shifter
module dsp_accumulator_datapath (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire dsp_acc_pkg::op_kind_t op_kind,
  input wire logic op_target,
  input wire logic op_subtract,
  input wire logic op_zero_acc,
  input wire logic [39:0] op_operand,
  input wire dsp_acc_pkg::wb_mode_t op_writeback,
  input wire logic op_round,
  input wire logic [15:0] op_addr,
  input wire logic [5:0] op_shift_amt,
  input wire logic op_shift_arith,
  input wire dsp_acc_pkg::shift_src_t op_shift_src,
  input wire logic op_shift_dsp,
  input wire logic [15:0] xbus_in,
  output logic xbus_wr_valid,
  output logic [15:0] xbus_wr_addr,
  output logic [15:0] xbus_wr_data,
  output logic [15:0] shift_result,
  output logic shift_valid,
  output logic arith_trap,
  output logic either_guard_ovf,
  output logic either_clip_flag
);
  import dsp_acc_pkg::*;

  typedef struct packed {
    logic [39:0] acc_first;
    logic [39:0] acc_second;
    logic [1:0] guard;
    logic [1:0] clip;
    logic [7:0] cfg;
    logic [2:0] trap_en;
    logic [15:0] wb_ptr;
    logic wr_valid;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] shift_res;
    logic shift_valid;
    logic trap;
    logic dp_write;
    logic [3:0] dp_index;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Rounded or truncated upper word, then optional store clipping
  function automatic logic [15:0] store_word(input logic [39:0] a, input logic do_round,
                                             input logic conv, input logic clip_en);
    logic inc;
    logic [23:0] val;
    logic [15:0] w;
    inc = do_round && a[15] && (!conv || a[15:0] != ROUND_HALF || a[16]);
    val = a[39:16] + {23'h0, inc};
    w = val[15:0];
    if (clip_en) begin
      if (!a[39] && val > STORE_POS_LIMIT) begin
        w = STORE_POS_WORD;
      end else if (a[39] && val < STORE_NEG_LIMIT) begin
        w = STORE_NEG_WORD;
      end
    end
    return w;
  endfunction : store_word

  logic [39:0] acc_tgt;
  logic [39:0] acc_other;
  logic [39:0] base;
  logic [39:0] addend;
  logic [39:0] sum;
  logic ovf39;
  logic ovf31;
  logic gov;
  logic clip_on;
  logic true_sign;
  logic ahb_take;
  logic mapped;
  logic [5:0] shift_mag;
  logic [39:0] shift_src;
  logic [39:0] shift_out;
  logic [31:0] read_value;

  assign acc_tgt = op_target ? s_q.acc_second : s_q.acc_first;
  assign acc_other = op_target ? s_q.acc_first : s_q.acc_second;
  // Subtraction feeds complemented data with the borrow entering as a carry of one
  assign base = op_zero_acc ? ACC_RESET : acc_tgt;
  assign addend = op_subtract ? ~op_operand : op_operand;
  assign sum = base + addend + {39'h0, op_subtract};
  assign ovf39 = (base[39] == addend[39]) && (sum[39] != base[39]);
  assign ovf31 = !((&sum[39:31]) || !(|sum[39:31]));
  assign gov = !((&sum[39:32]) || !(|sum[39:32]));
  assign clip_on = op_target ? s_q.cfg[CFG_SECOND_CLIP_EN] : s_q.cfg[CFG_FIRST_CLIP_EN];
  // After a bit 39 overflow the result sign is wrong, so take the operand sign
  assign true_sign = ovf39 ? base[39] : sum[39];

  assign shift_mag = op_shift_amt[5] ? 6'(-op_shift_amt) : op_shift_amt;
  always_comb begin
    case (op_shift_src)
      SRC_FIRST: shift_src = s_q.acc_first;
      SRC_SECOND: shift_src = s_q.acc_second;
      SRC_XBUS: begin
        if (op_shift_amt[5]) begin
          shift_src = {{24{xbus_in[15]}}, xbus_in};
        end else begin
          shift_src = {{8{op_shift_arith & xbus_in[15]}}, xbus_in, 16'h0000};
        end
      end
      default: shift_src = ACC_RESET;
    endcase
    if (op_shift_amt[5]) begin
      shift_out = shift_src << shift_mag;
    end else if (op_shift_arith) begin
      shift_out = 40'($signed(shift_src) >>> shift_mag);
    end else begin
      shift_out = shift_src >> shift_mag;
    end
  end

  assign ahb_take = hsel && hready && htrans[1];
  assign mapped = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'b00);

  always_comb begin
    case (haddr[5:2])
      IDX_CORE_CONFIG: read_value = {24'h0, s_q.cfg};
      IDX_TRAP_CONTROL: read_value = {29'h0, s_q.trap_en};
      IDX_STATUS: read_value = {26'h0, |s_q.clip, |s_q.guard, s_q.clip, s_q.guard};
      IDX_WB_POINTER: read_value = {16'h0, s_q.wb_ptr};
      IDX_ACC_FIRST_LO: read_value = s_q.acc_first[31:0];
      IDX_ACC_FIRST_HI: read_value = {24'h0, s_q.acc_first[39:32]};
      IDX_ACC_SECOND_LO: read_value = s_q.acc_second[31:0];
      IDX_ACC_SECOND_HI: read_value = {24'h0, s_q.acc_second[39:32]};
      default: read_value = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic [39:0] acc_new;
    logic guard_new;
    logic clip_set;
    logic [15:0] wb_word;
    acc_new = sum;
    guard_new = gov;
    clip_set = 1'b0;
    wb_word = 16'h0000;
    s_d = s_q;
    s_d.wr_valid = 1'b0;
    s_d.shift_valid = 1'b0;
    s_d.trap = 1'b0;
    // Register writes land in the data phase, before the datapath so hardware sets win
    if (s_q.dp_write) begin
      case (s_q.dp_index)
        IDX_CORE_CONFIG: s_d.cfg = hwdata[7:0];
        IDX_TRAP_CONTROL: s_d.trap_en = hwdata[2:0];
        IDX_STATUS: begin
          if (!hwdata[ST_FIRST_CLIP]) s_d.clip[0] = 1'b0;
          if (!hwdata[ST_SECOND_CLIP]) s_d.clip[1] = 1'b0;
        end
        IDX_WB_POINTER: s_d.wb_ptr = hwdata[15:0];
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    s_d.dp_write = ahb_take && hwrite && mapped;
    s_d.dp_index = haddr[5:2];
    if (ahb_take && !hwrite) begin
      s_d.rdata = mapped ? read_value : 32'h0000_0000;
    end
    case (op_kind)
      OP_ACCUM: begin
        if (clip_on && s_q.cfg[CFG_CLIP_WIDTH]) begin
          if (ovf39) acc_new = true_sign ? SAT40_NEG : SAT40_POS;
          clip_set = ovf39;
        end else if (clip_on) begin
          guard_new = 1'b0;
          if (ovf31) acc_new = true_sign ? SAT32_NEG : SAT32_POS;
          clip_set = ovf31;
        end else begin
          clip_set = ovf39;
          s_d.trap = ovf39 && s_q.trap_en[TRAP_WRAP];
        end
        if (guard_new && s_q.trap_en[op_target ? TRAP_SECOND_GUARD : TRAP_FIRST_GUARD]) begin
          s_d.trap = 1'b1;
        end
        if (op_target) begin
          s_d.acc_second = acc_new;
        end else begin
          s_d.acc_first = acc_new;
        end
        s_d.guard[op_target] = guard_new;
        if (clip_set) s_d.clip[op_target] = 1'b1;
        // Write-back always rounds the accumulator not being targeted
        wb_word = store_word(acc_other, 1'b1, s_q.cfg[CFG_ROUND_STYLE],
                             s_q.cfg[CFG_STORE_CLIP_EN]);
        case (op_writeback)
          WB_REG_DIRECT: s_d.wb_ptr = wb_word;
          WB_POST_INC: begin
            s_d.wr_valid = 1'b1;
            s_d.wr_addr = s_q.wb_ptr;
            s_d.wr_data = wb_word;
            s_d.wb_ptr = s_q.wb_ptr + WB_STEP;
          end
          default: s_d.wb_ptr = s_d.wb_ptr;
        endcase
      end
      OP_STORE: begin
        s_d.wr_valid = 1'b1;
        s_d.wr_addr = op_addr;
        s_d.wr_data = store_word(acc_tgt, op_round, s_q.cfg[CFG_ROUND_STYLE],
                                 s_q.cfg[CFG_STORE_CLIP_EN]);
      end
      OP_SHIFT: begin
        if (op_shift_dsp) begin
          if (op_target) begin
            s_d.acc_second = shift_out;
          end else begin
            s_d.acc_first = shift_out;
          end
        end else begin
          s_d.shift_valid = 1'b1;
          s_d.shift_res = op_shift_amt[5] ? shift_out[15:0] : shift_out[31:16];
        end
      end
      default: s_d.trap = s_d.trap;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.cfg <= CFG_RESET;
      s_q.trap_en <= TRAP_EN_RESET;
      s_q.wb_ptr <= WB_PTR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero wait states: read data is captured at the address phase edge
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign xbus_wr_valid = s_q.wr_valid;
  assign xbus_wr_addr = s_q.wr_addr;
  assign xbus_wr_data = s_q.wr_data;
  assign shift_result = s_q.shift_res;
  assign shift_valid = s_q.shift_valid;
  assign arith_trap = s_q.trap;
  assign either_guard_ovf = |s_q.guard;
  assign either_clip_flag = |s_q.clip;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_guard_either_or:
    assert property (ahb_take && !hwrite && mapped && haddr[5:2] == IDX_STATUS
                     |=> hrdata[ST_EITHER_GUARD]
                     == ($past(s_q.guard[0]) | $past(s_q.guard[1])))
    else $error("combined guard bit differs from OR of guard flags");

  a_clip_flag_sticky:
    assert property (s_q.clip[0] && !(s_q.dp_write && s_q.dp_index == IDX_STATUS
                     && !hwdata[ST_FIRST_CLIP]) |=> s_q.clip[0])
    else $error("clip flag cleared without a software write");

  a_width32_no_guard:
    assert property (op_kind == OP_ACCUM && clip_on && !s_q.cfg[CFG_CLIP_WIDTH]
                     |=> !s_q.guard[$past(op_target)])
    else $error("guard flag set in 32-bit clip mode");

  a_wrap_trap_fires:
    assert property (op_kind == OP_ACCUM && !clip_on && ovf39 && s_q.trap_en[TRAP_WRAP]
                     |=> arith_trap && either_clip_flag)
    else $error("wrap overflow did not trap");

  a_sat40_extreme:
    assert property (op_kind == OP_ACCUM && !op_target && clip_on && s_q.cfg[CFG_CLIP_WIDTH]
                     && ovf39 |=> (s_q.acc_first == SAT40_POS || s_q.acc_first == SAT40_NEG))
    else $error("40-bit clip did not load an extreme value");

  a_post_inc_step:
    assert property (op_kind == OP_ACCUM && op_writeback == WB_POST_INC
                     |=> xbus_wr_valid && xbus_wr_addr == $past(s_q.wb_ptr)
                     && s_q.wb_ptr == $past(s_q.wb_ptr) + WB_STEP)
    else $error("post-increment write-back address or step wrong");

  a_store_passthru:
    assert property (op_kind == OP_STORE && !op_round && !s_q.cfg[CFG_STORE_CLIP_EN]
                     ##1 xbus_wr_valid |-> xbus_wr_data == $past(acc_tgt[31:16]))
    else $error("unclipped truncated store modified data");

  a_round_conv_up:
    assert property (op_kind == OP_STORE && op_round && !s_q.cfg[CFG_ROUND_STYLE]
                     && !s_q.cfg[CFG_STORE_CLIP_EN] && acc_tgt[15]
                     |=> xbus_wr_data == 16'($past(acc_tgt[31:16]) + 16'h0001))
    else $error("conventional rounding did not increment");

  a_shift_zero_same:
    assert property (op_kind == OP_SHIFT && op_shift_src == SRC_XBUS && !op_shift_dsp
                     && op_shift_amt == 6'h00 |=> shift_valid && shift_result == $past(xbus_in))
    else $error("zero shift changed the operand");

endmodule : dsp_accumulator_datapath

// File: dv/xbus_mem_model.sv
// Data-space memory standing behind the X bus write port
module xbus_mem_model (
  input wire logic hclk,
  input wire logic xbus_wr_valid,
  input wire logic [15:0] xbus_wr_addr,
  input wire logic [15:0] xbus_wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:255];
  int wr_cnt = 0;
  // Word writes only, so address bit 0 is dropped
  always @(posedge hclk) begin
    if (xbus_wr_valid === 1'b1) begin
      mem[xbus_wr_addr[8:1]] <= xbus_wr_data;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule : xbus_mem_model

// File: dv/dsp_accumulator_datapath_test.sv
// Self-checking bench for the accumulator datapath
module dsp_accumulator_datapath_test;
  import dsp_acc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  op_kind_t op_kind;
  wb_mode_t op_writeback;
  shift_src_t op_shift_src;
  logic op_target, op_subtract, op_zero_acc, op_round, op_shift_arith, op_shift_dsp;
  logic [39:0] op_operand, acc;
  logic [15:0] op_addr, xbus_in, xbus_wr_addr, xbus_wr_data, shift_result;
  logic [5:0] op_shift_amt;
  logic xbus_wr_valid, shift_valid, arith_trap, either_guard_ovf, either_clip_flag;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] s_cfg [8] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h00, 8'h20, 8'h00, 8'h20};
  logic [39:0] s_acc [8] = '{40'h00_1234_8000, 40'h00_1234_8000, 40'h00_1234_8000,
    40'h00_1235_8000, 40'h00_1234_7FFF, 40'h00_8000_0000, 40'h00_8000_0000,
    40'hFF_7FFF_0000};
  logic [15:0] s_exp [8] = '{16'h1234, 16'h1235, 16'h1234, 16'h1236, 16'h1234, 16'h7FFF,
    16'h8000, 16'h8000};
  logic [7:0] s_round = 8'h1E;
  logic [15:0] h_in [5] = '{16'h8001, 16'h8001, 16'h1234, 16'h1234, 16'h8001};
  logic [5:0] h_amt [5] = '{6'h01, 6'h01, 6'h3C, 6'h00, 6'h10};
  logic [15:0] h_exp [5] = '{16'h4000, 16'hC000, 16'h2340, 16'h1234, 16'h0000};
  logic [4:0] h_ar = 5'h02;

  dsp_accumulator_datapath DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .op_kind(op_kind),
    .op_target(op_target), .op_subtract(op_subtract), .op_zero_acc(op_zero_acc),
    .op_operand(op_operand), .op_writeback(op_writeback), .op_round(op_round),
    .op_addr(op_addr), .op_shift_amt(op_shift_amt), .op_shift_arith(op_shift_arith),
    .op_shift_src(op_shift_src), .op_shift_dsp(op_shift_dsp), .xbus_in(xbus_in),
    .xbus_wr_valid(xbus_wr_valid), .xbus_wr_addr(xbus_wr_addr), .xbus_wr_data(xbus_wr_data),
    .shift_result(shift_result), .shift_valid(shift_valid), .arith_trap(arith_trap),
    .either_guard_ovf(either_guard_ovf), .either_clip_flag(either_clip_flag));

  xbus_mem_model xm (.hclk(hclk), .xbus_wr_valid(xbus_wr_valid),
    .xbus_wr_addr(xbus_wr_addr), .xbus_wr_data(xbus_wr_data));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Whole run needs well under 3000 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic rdacc(input logic t);
    ahb(1'b0, t ? 32'h18 : 32'h10, 32'h0);
    acc[31:0] = rd;
    ahb(1'b0, t ? 32'h1C : 32'h14, 32'h0);
    acc[39:32] = rd[7:0];
  endtask : rdacc

  // Caller sets the qualifiers at the same edge; kind drops one cycle later
  task automatic fire(input op_kind_t k);
    op_kind <= k;
    @(posedge hclk);
    op_kind <= OP_NONE;
    #1;
  endtask : fire

  task automatic accop(input logic t, input logic s, input logic z, input logic [39:0] v,
                       input wb_mode_t wb);
    @(posedge hclk);
    op_target <= t;
    op_subtract <= s;
    op_zero_acc <= z;
    op_operand <= v;
    op_writeback <= wb;
    fire(OP_ACCUM);
  endtask : accop

  task automatic load(input logic t, input logic [39:0] v);
    accop(t, 1'b0, 1'b1, v, WB_NONE);
  endtask : load

  task automatic t_regs();
    check("reset trap", arith_trap, 1'b0);
    check("reset write strobe", xbus_wr_valid, 1'b0);
    check("reset shift strobe", shift_valid, 1'b0);
    ahb(1'b0, 32'h8, 32'h0);
    check("status reset", rd, 32'h0);
    check("okay response", hresp, 1'b0);
    ahb(1'b1, 32'h24, 32'h7);
    ahb(1'b0, 32'h4, 32'h0);
    check("trap after unmapped write", rd, 32'h0);
    ahb(1'b1, 32'h0, 32'hB2);
    ahb(1'b0, 32'h0, 32'h0);
    check("config", rd, 32'hB2);
    ahb(1'b0, 32'h20, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask : t_regs

  task automatic t_sat40();
    ahb(1'b1, 32'h0, 32'hD0);
    ahb(1'b1, 32'h4, 32'h0);
    load(1'b0, 40'h5);
    accop(1'b0, 1'b1, 1'b0, 40'h3, WB_NONE);
    rdacc(1'b0);
    check("subtract", acc, 40'h2);
    load(1'b0, SAT40_POS);
    accop(1'b0, 1'b0, 1'b0, 40'h1, WB_NONE);
    rdacc(1'b0);
    check("clip40 pos", acc, SAT40_POS);
    ahb(1'b0, 32'h8, 32'h0);
    check("status", rd, 32'h35);
    check("either guard", either_guard_ovf, 1'b1);
    load(1'b0, 40'h10);
    ahb(1'b0, 32'h8, 32'h0);
    check("sticky", rd, 32'h24);
    ahb(1'b1, 32'h8, 32'h0);
    ahb(1'b0, 32'h8, 32'h0);
    check("cleared", rd, 32'h0);
    load(1'b1, SAT40_NEG);
    accop(1'b1, 1'b1, 1'b0, 40'h1, WB_NONE);
    rdacc(1'b1);
    check("clip40 neg", acc, SAT40_NEG);
    ahb(1'b0, 32'h8, 32'h0);
    check("second flags", rd, 32'h3A);
    check("either clip", either_clip_flag, 1'b1);
  endtask : t_sat40

  task automatic t_sat32();
    load(1'b1, 40'h0);
    ahb(1'b1, 32'h0, 32'h80);
    ahb(1'b1, 32'h8, 32'h0);
    load(1'b0, SAT32_POS);
    accop(1'b0, 1'b0, 1'b0, 40'h1, WB_NONE);
    rdacc(1'b0);
    check("clip32 pos", acc, SAT32_POS);
    ahb(1'b0, 32'h8, 32'h0);
    check("no guard in 32", rd, 32'h24);
    load(1'b0, SAT32_NEG);
    accop(1'b0, 1'b1, 1'b0, 40'h1, WB_NONE);
    rdacc(1'b0);
    check("clip32 neg", acc, SAT32_NEG);
  endtask : t_sat32

  task automatic t_wrap();
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b1, 32'h4, 32'h4);
    ahb(1'b1, 32'h8, 32'h0);
    load(1'b0, SAT40_POS);
    accop(1'b0, 1'b0, 1'b0, 40'h1, WB_NONE);
    check("wrap trap", arith_trap, 1'b1);
    rdacc(1'b0);
    check("wrapped", acc, SAT40_NEG);
    ahb(1'b0, 32'h8, 32'h0);
    check("wrap flag", rd[2], 1'b1);
    ahb(1'b1, 32'h0, 32'h90);
    load(1'b0, SAT40_POS);
    accop(1'b0, 1'b0, 1'b0, 40'h1, WB_NONE);
    check("no trap when clipping", arith_trap, 1'b0);
    ahb(1'b1, 32'h4, 32'h1);
    load(1'b0, 40'h01_0000_0000);
    check("guard trap", arith_trap, 1'b1);
    ahb(1'b1, 32'h4, 32'h0);
  endtask : t_wrap

  task automatic t_store();
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, 32'h0, {24'h0, s_cfg[i]});
      load(1'b1, s_acc[i]);
      @(posedge hclk);
      op_target <= 1'b1;
      op_round <= s_round[i];
      op_addr <= 16'h0040 + 16'(2 * i);
      fire(OP_STORE);
      @(posedge hclk);
      #1;
      check("stored word", xm.mem[8'h20 + 8'(i)], s_exp[i]);
    end
    rdacc(1'b1);
    check("source kept", acc, 40'hFF_7FFF_0000);
    check("write count", xm.wr_cnt, 8);
  endtask : t_store

  task automatic t_wb();
    ahb(1'b1, 32'h0, 32'h0);
    load(1'b1, 40'h00_4321_8000);
    ahb(1'b1, 32'hC, 32'h100);
    accop(1'b0, 1'b0, 1'b0, 40'h0, WB_POST_INC);
    check("wb valid", xbus_wr_valid, 1'b1);
    check("wb addr", xbus_wr_addr, 16'h0100);
    check("wb data", xbus_wr_data, 16'h4322);
    ahb(1'b0, 32'hC, 32'h0);
    check("pointer step", rd, 32'h102);
    accop(1'b0, 1'b0, 1'b0, 40'h0, WB_REG_DIRECT);
    ahb(1'b0, 32'hC, 32'h0);
    check("pointer load", rd, 32'h4322);
  endtask : t_wb

  task automatic t_shift();
    for (int i = 0; i < 5; i++) begin
      @(posedge hclk);
      xbus_in <= h_in[i];
      op_shift_amt <= h_amt[i];
      op_shift_arith <= h_ar[i];
      op_shift_src <= SRC_XBUS;
      op_shift_dsp <= 1'b0;
      fire(OP_SHIFT);
      check("shift valid", shift_valid, 1'b1);
      check("shift result", shift_result, h_exp[i]);
    end
    load(1'b0, 40'h00_0000_0100);
    @(posedge hclk);
    op_shift_src <= SRC_FIRST;
    op_shift_amt <= 6'h38;
    op_shift_dsp <= 1'b1;
    op_target <= 1'b1;
    fire(OP_SHIFT);
    rdacc(1'b1);
    check("dsp shift", acc, 40'h00_0001_0000);
    @(posedge hclk);
    op_shift_src <= SRC_SECOND;
    op_shift_amt <= 6'h00;
    op_shift_dsp <= 1'b0;
    fire(OP_SHIFT);
    check("second source", shift_result, 16'h0001);
  endtask : t_shift

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, op_target, op_subtract, op_zero_acc, op_round} = '0;
    {op_shift_arith, op_shift_dsp, haddr, hwdata, htrans} = '0;
    {op_operand, op_addr, xbus_in, op_shift_amt} = '0;
    hsize = 3'h2;
    op_kind = OP_NONE;
    op_writeback = WB_NONE;
    op_shift_src = SRC_FIRST;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_sat40();
    t_sat32();
    t_wrap();
    t_store();
    t_wb();
    t_shift();
    print_verdict();
  end
endmodule : dsp_accumulator_datapath_test
